/* File: design/serial_port_handshake_ctrl_consts.vh */
// constants for the four-port serial handshake and driver control block
// assumes a 250 MHz logic clock and register numbers used as word addresses
`ifndef SERIAL_PORT_HANDSHAKE_CTRL_CONSTS_VH
`define SERIAL_PORT_HANDSHAKE_CTRL_CONSTS_VH

// ==========================================================================
// register numbers (word addresses on the register port)
`define REG_P1_CHANNEL_DELAY_STAT 16'h0818
`define REG_P2_CHANNEL_DELAY_STAT 16'h0838
`define REG_P3_CHANNEL_DELAY_STAT 16'h0858
`define REG_P4_CHANNEL_DELAY_STAT 16'h0878
`define REG_P1_REMOTE_CTS_DELAY 16'h1F6A
`define REG_P2_REMOTE_CTS_DELAY 16'h1F8A
`define REG_P3_REMOTE_CTS_DELAY 16'h1FAA
`define REG_P4_REMOTE_CTS_DELAY 16'h1FCA
`define REG_P1_CTS_DELAY_OR_PAD 16'h1F80
`define REG_P2_CTS_DELAY_OR_PAD 16'h1FA0
`define REG_P3_CTS_DELAY_OR_PAD 16'h1FC0
`define REG_P4_CTS_DELAY_OR_PAD 16'h1FE0

// ==========================================================================
// reset values
`define RST_CFG_WORD 16'h0000
`define RST_STAT_WORD 16'h0000
`define RST_PAD_COUNT 16'h000A

// ==========================================================================
// port modes (4-bit code per port)
`define MODE_NATIVE_PLC_PROTOCOL 4'h0
`define MODE_NETWORK_BRIDGE 4'h1
`define MODE_POWER_METER 4'h2
`define MODE_THIRD_PARTY_PLC 4'h3
`define MODE_GATEWAY 4'h4
`define MODE_TRANSPARENT 4'h5
`define MODE_MULTIDROP 4'h6
`define MODE_PERIPHERAL 4'h7
`define MODE_SHARE 4'h8
`define MODE_SLAVE_REGISTER 4'h9
`define MODE_REMOTE_NETWORK 4'hA

// ==========================================================================
// driver modes (2-bit code per port)
`define DRIVE_POINT_LINK 2'h0
`define DRIVE_FOUR_WIRE 2'h1
`define DRIVE_HALF_DUPLEX 2'h2
`define DRIVE_TWO_WIRE 2'h3

// ==========================================================================
// timing and limits
`define PAD_COUNT_MIN 16'h000A
`define CTS_DELAY_UNIT_MILLISEC 10
`define MCLK_KHZ 250000
`define CTS_UNIT_CYCLES (`CTS_DELAY_UNIT_MILLISEC * `MCLK_KHZ)

`endif

/* File: design/sync_two_stage.v */
// two flip-flop synchroniser for a group of independent level inputs
// assumes each bit is a slow level; no bit relation across the group is kept
`timescale 1ns/1ns
module sync_two_stage
#(
   parameter WIDTH = 4
)
(
   input wire mclk,
   input wire rst_b,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   // first stage feeds only the second stage
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_r <= {WIDTH{1'b0}};
         sync_r <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;

endmodule

/* File: design/serial_port_handshake_ctrl.v */
// four-port serial handshake, clear-to-send gating and line driver control
// assumes an external shifter per port that starts a character only on
// tx_start and reports tx_busy while a character is shifting out; cts_active
// is the resolved clear-to-send pin level, already high when the pair is open
//
// Contract
// RULE1: active or open clear-to-send lets a port send queued data in any mode. Here modes 6 to 10 also wait for the RULE4 delay.
// RULE2: inactive clear-to-send holds pending characters until it returns active.
// RULE3: attached equipment must not hold clear-to-send restraint forever.
// RULE4: delay-capable modes wait programmable 10 millisecond units after clear-to-send rises.
// RULE5: remote network mode takes its delay from the remote delay registers.
// RULE6: other delay-capable modes take delay from the shared delay or pad registers.
// RULE7: four and two wire drives tri-state the driver while clear-to-send inactive.
// RULE8: all other drive modes keep the transmit driver always enabled.
// RULE9: installer should loop request-to-send back to clear-to-send for those drives.
// RULE10: flow-control modes keep request-to-send active unless receive buffers congest.
// RULE11: push-to-talk modes raise request-to-send only while data remains to send.
// RULE12: a modem keys up on request-to-send and answers through clear-to-send.
// RULE13: pad-count modes use programmed pad count, with ten as floor and default.
// RULE14: pad count shares the per-port registers with the clear-to-send delay.
// RULE15: each port counts bytes sent between trailing checksum and acknowledgement.
// RULE16: software should set pad count ten percent above the measured statistic.
// RULE17: half duplex keeps driver on but disables receiver while transmitting.
// RULE18: two wire drive also disables the receiver while transmitting.
// RULE19: point link drive keeps driver and receiver enabled at all times.
// RULE20: clear-to-send passes a two-stage synchroniser before any use.
// RULE21: a character in flight finishes; no new one starts while restrained.
`timescale 1ns/1ns
`include "serial_port_handshake_ctrl_consts.vh"
module serial_port_handshake_ctrl
#(
   parameter PORTS = 4,
   parameter CTS_UNIT_CYCLES = `CTS_UNIT_CYCLES
)
(
   input wire mclk,
   input wire rst_b,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   output wire [15:0] reg_rdata,
   output wire reg_ack,
   input wire [15:0] port_mode,
   input wire [7:0] drive_mode,
   input wire [3:0] cts_active,
   input wire [3:0] tx_pending,
   input wire [3:0] tx_start_req,
   input wire [3:0] tx_busy,
   input wire [3:0] rx_congested,
   input wire [3:0] checksum_sent,
   input wire [3:0] byte_sent,
   input wire [3:0] ack_seen,
   output wire [3:0] tx_start,
   output wire [3:0] rts_active,
   output wire [3:0] drv_en,
   output wire [3:0] rcv_en,
   output wire [63:0] pad_count
);

   // =======================================================================
   // configuration storage
   reg [15:0] remote_delay_r [0:3];
   reg [15:0] delay_pad_r [0:3];
   reg [15:0] reg_rdata_r;
   reg reg_ack_r;
   reg [15:0] rdata_nxt;
   wire [63:0] stat_flat;
   wire [3:0] cts_sync;
   integer k;

   // RULE20: synchronise clear-to-send
   sync_two_stage #(.WIDTH(4)) cts_sync_u
   (
      .mclk(mclk),
      .rst_b(rst_b),
      .async_in(cts_active),
      .sync_out(cts_sync)
   );

   // =======================================================================
   // register port: writes to statistic or unmapped numbers are dropped
   // RULE5: remote delay registers
   // RULE14: shared delay or pad registers
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (k = 0; k < 4; k = k + 1)
         begin
            remote_delay_r[k] <= `RST_CFG_WORD;
            delay_pad_r[k] <= `RST_CFG_WORD;
         end
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `REG_P1_REMOTE_CTS_DELAY:
               remote_delay_r[0] <= reg_wdata;
            `REG_P2_REMOTE_CTS_DELAY:
               remote_delay_r[1] <= reg_wdata;
            `REG_P3_REMOTE_CTS_DELAY:
               remote_delay_r[2] <= reg_wdata;
            `REG_P4_REMOTE_CTS_DELAY:
               remote_delay_r[3] <= reg_wdata;
            `REG_P1_CTS_DELAY_OR_PAD:
               delay_pad_r[0] <= reg_wdata;
            `REG_P2_CTS_DELAY_OR_PAD:
               delay_pad_r[1] <= reg_wdata;
            `REG_P3_CTS_DELAY_OR_PAD:
               delay_pad_r[2] <= reg_wdata;
            `REG_P4_CTS_DELAY_OR_PAD:
               delay_pad_r[3] <= reg_wdata;
            default:
               ;
         endcase
      end
   end

   // read mux; unmapped numbers read as zero
   always @*
   begin
      rdata_nxt = 16'h0000;
      case (reg_addr)
         `REG_P1_CHANNEL_DELAY_STAT:
            rdata_nxt = stat_flat[15:0];
         `REG_P2_CHANNEL_DELAY_STAT:
            rdata_nxt = stat_flat[31:16];
         `REG_P3_CHANNEL_DELAY_STAT:
            rdata_nxt = stat_flat[47:32];
         `REG_P4_CHANNEL_DELAY_STAT:
            rdata_nxt = stat_flat[63:48];
         `REG_P1_REMOTE_CTS_DELAY:
            rdata_nxt = remote_delay_r[0];
         `REG_P2_REMOTE_CTS_DELAY:
            rdata_nxt = remote_delay_r[1];
         `REG_P3_REMOTE_CTS_DELAY:
            rdata_nxt = remote_delay_r[2];
         `REG_P4_REMOTE_CTS_DELAY:
            rdata_nxt = remote_delay_r[3];
         `REG_P1_CTS_DELAY_OR_PAD:
            rdata_nxt = delay_pad_r[0];
         `REG_P2_CTS_DELAY_OR_PAD:
            rdata_nxt = delay_pad_r[1];
         `REG_P3_CTS_DELAY_OR_PAD:
            rdata_nxt = delay_pad_r[2];
         `REG_P4_CTS_DELAY_OR_PAD:
            rdata_nxt = delay_pad_r[3];
         default:
            rdata_nxt = 16'h0000;
      endcase
   end

   // one-cycle acknowledge for either access; data holds until next read
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata_r <= 16'h0000;
         reg_ack_r <= 1'b0;
      end
      else
      begin
         reg_ack_r <= reg_wr | reg_rd;
         if (reg_rd)
            reg_rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = reg_rdata_r;
   assign reg_ack = reg_ack_r;

   // =======================================================================
   // per-port handshake logic
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : port_g
         wire [3:0] mode;
         wire [1:0] drive;
         wire cts_ok;
         wire delay_mode;
         wire flow_mode;
         wire pad_mode;
         wire [15:0] delay_units;
         wire gate_ok;
         wire sending;
         reg cts_prev_r;
         reg armed_r;
         reg [15:0] units_r;
         reg [31:0] pre_r;
         reg tx_start_r;
         reg rts_r;
         reg drv_en_r;
         reg rcv_en_r;
         reg [15:0] pad_r;
         reg stat_run_r;
         reg [15:0] stat_cnt_r;
         reg [15:0] stat_r;

         assign mode = port_mode[4*i+3:4*i];
         assign drive = drive_mode[2*i+1:2*i];
         assign cts_ok = cts_sync[i];
         assign delay_mode = (mode >= `MODE_MULTIDROP) && (mode <= `MODE_REMOTE_NETWORK);
         assign flow_mode = (mode <= `MODE_TRANSPARENT);
         assign pad_mode = (mode <= `MODE_POWER_METER);
         // RULE5: remote network mode delay source
         // RULE6: other modes use shared register
         assign delay_units = (mode == `MODE_REMOTE_NETWORK) ? remote_delay_r[i]
                                                              : delay_pad_r[i];
         // RULE1: open or active clear-to-send
         // RULE2: inactive pin holds characters
         assign gate_ok = cts_ok & (~delay_mode | armed_r);
         assign sending = tx_busy[i] | tx_start_r;

         // RULE4: delay after clear-to-send rise
         // the prescaler restarts on each rise so a short drop re-arms in full
         always @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               cts_prev_r <= 1'b0;
               armed_r <= 1'b0;
               units_r <= 16'h0000;
               pre_r <= 32'h00000000;
            end
            else
            begin
               cts_prev_r <= cts_ok;
               if (!cts_ok)
               begin
                  armed_r <= 1'b0;
                  units_r <= 16'h0000;
               end
               else if (!cts_prev_r)
               begin
                  armed_r <= (delay_units == 16'h0000);
                  units_r <= delay_units;
                  pre_r <= CTS_UNIT_CYCLES - 1;
               end
               else if (units_r != 16'h0000)
               begin
                  if (pre_r == 32'h00000000)
                  begin
                     pre_r <= CTS_UNIT_CYCLES - 1;
                     units_r <= units_r - 16'h0001;
                     if (units_r == 16'h0001)
                        armed_r <= 1'b1;
                  end
                  else
                     pre_r <= pre_r - 32'h00000001;
               end
            end
         end

         // RULE21: start only between characters
         // a character already started is never cut; only new starts wait
         always @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
               tx_start_r <= 1'b0;
            else
               tx_start_r <= tx_start_req[i] & gate_ok & ~tx_busy[i] & ~tx_start_r;
         end

         // request-to-send by mode group
         always @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
               rts_r <= 1'b0;
            else if (flow_mode)
               // RULE10: flow control on congestion
               rts_r <= ~rx_congested[i];
            else
               // RULE11: push to talk while data
               rts_r <= tx_pending[i] | sending;
         end

         // driver and receiver enables
         always @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               drv_en_r <= 1'b1;
               rcv_en_r <= 1'b1;
            end
            else
            begin
               case (drive)
                  `DRIVE_FOUR_WIRE:
                  begin
                     // RULE7: tri-state on inactive pin
                     drv_en_r <= cts_ok;
                     rcv_en_r <= 1'b1;
                  end
                  `DRIVE_HALF_DUPLEX:
                  begin
                     // RULE17: receiver off while sending
                     drv_en_r <= 1'b1;
                     rcv_en_r <= ~sending;
                  end
                  `DRIVE_TWO_WIRE:
                  begin
                     // RULE7: tri-state on inactive pin
                     // RULE18: receiver off while sending
                     drv_en_r <= cts_ok;
                     rcv_en_r <= ~sending;
                  end
                  default:
                  begin
                     // RULE8: driver always on
                     // RULE19: full duplex both enabled
                     drv_en_r <= 1'b1;
                     rcv_en_r <= 1'b1;
                  end
               endcase
            end
         end

         // RULE13: pad count with floor of ten
         // outside pad modes the register means a delay, so the floor holds
         always @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
               pad_r <= `RST_PAD_COUNT;
            else if (pad_mode && (delay_pad_r[i] > `PAD_COUNT_MIN))
               pad_r <= delay_pad_r[i];
            else
               pad_r <= `PAD_COUNT_MIN;
         end

         // RULE15: bytes between checksum and ack
         // counter saturates instead of wrapping on a lost acknowledgement
         always @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               stat_run_r <= 1'b0;
               stat_cnt_r <= 16'h0000;
               stat_r <= `RST_STAT_WORD;
            end
            else if (checksum_sent[i])
            begin
               stat_run_r <= 1'b1;
               stat_cnt_r <= 16'h0000;
            end
            else if (stat_run_r)
            begin
               if (ack_seen[i])
               begin
                  stat_run_r <= 1'b0;
                  stat_r <= stat_cnt_r;
               end
               else if (byte_sent[i] && (stat_cnt_r != 16'hFFFF))
                  stat_cnt_r <= stat_cnt_r + 16'h0001;
            end
         end

         assign tx_start[i] = tx_start_r;
         assign rts_active[i] = rts_r;
         assign drv_en[i] = drv_en_r;
         assign rcv_en[i] = rcv_en_r;
         assign pad_count[16*i+15:16*i] = pad_r;
         assign stat_flat[16*i+15:16*i] = stat_r;
      end
   endgenerate

endmodule

/* File: verification/hs_ctrl_props.sv */
// concurrent checks on the handshake block, seen only through its ports
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
module hs_ctrl_props
#(
   parameter PORTS = 4,
   parameter CTS_UNIT_CYCLES = 8
)
(
   input wire mclk,
   input wire rst_b,
   input wire reg_wr,
   input wire reg_rd,
   input wire reg_ack,
   input wire [15:0] port_mode,
   input wire [7:0] drive_mode,
   input wire [3:0] cts_active,
   input wire [3:0] tx_pending,
   input wire [3:0] tx_start_req,
   input wire [3:0] tx_busy,
   input wire [3:0] rx_congested,
   input wire [3:0] tx_start,
   input wire [3:0] rts_active,
   input wire [3:0] drv_en,
   input wire [3:0] rcv_en,
   input wire [63:0] pad_count
);
reg [2:0] up_r;
wire up = up_r == 3'h7;
wire [3:0] gate_drv = {drive_mode[6], drive_mode[4], drive_mode[2], drive_mode[0]};
wire [3:0] mute_drv = {drive_mode[7], drive_mode[5], drive_mode[3], drive_mode[1]};
// ==========================================
// settle count: sync and output flops still hold reset values early on
always @(posedge mclk or negedge rst_b)
begin
   if (!rst_b)
      up_r <= 3'h0;
   else if (!up)
      up_r <= up_r + 3'h1;
end
default clocking cb_main @(posedge mclk);
endclocking
default disable iff (!rst_b);
chk_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("ack late");
chk_start_pulse: assert property ((tx_start & $past(tx_start)) == 4'h0) else $error("start twice");
chk_start_cause: assert property
   ((tx_start & ($past(tx_busy) | ~$past(tx_start_req))) == 4'h0)
   else $error("start without cause");
chk_cts_hold: assert property
   (up |-> (tx_start & ($past(cts_active, 2) | $past(cts_active, 3)
   | $past(cts_active, 4) | $past(cts_active, 5))) == tx_start) else $error("start held");
chk_drv_gate: assert property
   (up && $stable(drive_mode) && $stable(cts_active)
   && cts_active == $past(cts_active, 2) && cts_active == $past(cts_active, 3)
   && cts_active == $past(cts_active, 4) |-> drv_en == (~gate_drv | cts_active))
   else $error("driver enable");
chk_rts_flow: assert property
   (up && port_mode[3:0] <= 4'h5 && $stable(port_mode)
   |-> rts_active[0] == !$past(rx_congested[0])) else $error("flow rts");
chk_rts_talk: assert property
   (up && port_mode[3:0] >= 4'h6 && $stable(port_mode)
   |-> rts_active[0] == $past(tx_pending[0] | tx_busy[0] | tx_start[0])) else $error("talk rts");
chk_rcv_mute: assert property
   (up && $stable(drive_mode)
   |-> rcv_en == ~(mute_drv & $past(tx_busy | tx_start))) else $error("receiver enable");
chk_pad_floor: assert property
   (pad_count[15:0] >= 16'h000A && pad_count[31:16] >= 16'h000A
   && pad_count[47:32] >= 16'h000A && pad_count[63:48] >= 16'h000A) else $error("pad");
cover property (tx_start[0]);
cover property (up && !drv_en[0]);
cover property (reg_rd ##1 reg_ack);
endmodule

bind serial_port_handshake_ctrl hs_ctrl_props #(.PORTS(PORTS), .CTS_UNIT_CYCLES(CTS_UNIT_CYCLES))
   u_props (.mclk, .rst_b, .reg_wr, .reg_rd, .reg_ack, .port_mode, .drive_mode, .cts_active,
   .tx_pending, .tx_start_req, .tx_busy, .rx_congested, .tx_start, .rts_active, .drv_en,
   .rcv_en, .pad_count);

/* File: verification/line_partner.sv */
// far-side model: a keyed modem per port plus a character shifter
// assumes rts is looped to cts; hold_off lets the bench restrain a port
`timescale 1ns/1ns
module line_partner
(
   input wire mclk,
   input wire rst_b,
   input wire [3:0] rts_active,
   input wire [3:0] tx_start,
   input wire [3:0] hold_off,
   output reg [3:0] cts_active,
   output wire [3:0] tx_busy
);
reg [3:0] key_r;
reg [2:0] shift_r [0:3];
integer i;
// ==========================================
// key-up answer
// restraint is held while the bench asks or while rts is inactive, never indefinitely
always @(posedge mclk or negedge rst_b)
begin
   if (!rst_b)
   begin
      key_r <= 4'h0;
      cts_active <= 4'h0;
   end
   else
   begin
      key_r <= rts_active;
      cts_active <= key_r & ~hold_off;
   end
end
// character shifter
// busy rises the cycle after a start so the block never restarts mid-character
always @(posedge mclk or negedge rst_b)
begin
   for (i = 0; i < 4; i = i + 1)
      if (!rst_b)
         shift_r[i] <= 3'h0;
      else if (tx_start[i])
         shift_r[i] <= 3'h5;
      else if (shift_r[i] != 3'h0)
         shift_r[i] <= shift_r[i] - 3'h1;
end
assign tx_busy = {shift_r[3] != 3'h0, shift_r[2] != 3'h0, shift_r[1] != 3'h0, shift_r[0] != 3'h0};
endmodule

/* File: verification/serial_port_handshake_ctrl_tb.sv */
// self-checking bench for the handshake block with its far-side partner
// assumes a short delay unit so the ten millisecond waits fit in a brief run
`timescale 1ns/1ns
`include "serial_port_handshake_ctrl_consts.vh"
module serial_port_handshake_ctrl_tb;
localparam UNIT = 8;
reg mclk, rst_b, reg_wr, reg_rd;
reg [15:0] reg_addr, reg_wdata, port_mode, rv;
reg [7:0] drive_mode;
reg [3:0] tx_pending, tx_start_req, rx_congested, checksum_sent, byte_sent, ack_seen, hold_off;
wire [15:0] reg_rdata;
wire reg_ack;
wire [3:0] cts_active, tx_busy, tx_start, rts_active, drv_en, rcv_en;
wire [63:0] pad_count;
reg [16:0] notes [$];
reg [16:0] note;
reg [15:0] pad_v [0:3];
reg [31:0] rnd;
integer n_mismatch, n_tests, seed, i, n;
serial_port_handshake_ctrl #(.CTS_UNIT_CYCLES(UNIT)) DUT (.mclk(mclk), .rst_b(rst_b),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_ack(reg_ack), .port_mode(port_mode), .drive_mode(drive_mode),
   .cts_active(cts_active), .tx_pending(tx_pending), .tx_start_req(tx_start_req),
   .tx_busy(tx_busy), .rx_congested(rx_congested), .checksum_sent(checksum_sent),
   .byte_sent(byte_sent), .ack_seen(ack_seen), .tx_start(tx_start), .rts_active(rts_active),
   .drv_en(drv_en), .rcv_en(rcv_en), .pad_count(pad_count));
line_partner u_far (.mclk(mclk), .rst_b(rst_b), .rts_active(rts_active), .tx_start(tx_start),
   .hold_off(hold_off), .cts_active(cts_active), .tx_busy(tx_busy));
task chk_val(input [15:0] got, input [15:0] exp);
begin
   n_tests = n_tests + 1;
   if (got !== exp)
   begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
   end
end
endtask
task end_sim;
begin
   $display("tests %0d mismatches %0d", n_tests, n_mismatch);
   if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
   else
      $display("verification failed");
   $finish;
end
endtask
task cyc(input integer k);
   repeat (k) @(negedge mclk);
endtask
// one strobe, then an idle cycle so strobes never toggle twice in a step
task reg_acc(input rd, input [15:0] a, input [15:0] d, input [15:0] exp);
begin
   reg_rd = rd;
   reg_wr = !rd;
   reg_addr = a;
   reg_wdata = d;
   notes.push_back({rd, exp});
   cyc(1);
   reg_rd = 1'b0;
   reg_wr = 1'b0;
   cyc(1);
end
endtask
function [15:0] addr(input [15:0] base, input integer p);
   addr = base + {p[10:0], 5'h00};
endfunction
function [15:0] pad_exp(input [15:0] v);
   pad_exp = (v < `PAD_COUNT_MIN) ? `PAD_COUNT_MIN : v;
endfunction
// count from cts rise to the first start of port 0
task delay_run(input [3:0] mode, input integer units);
begin
   hold_off = 4'hF;
   tx_pending = 4'h0;
   tx_start_req = 4'h0;
   port_mode[3:0] = mode;
   cyc(10);
   tx_pending[0] = 1'b1;
   tx_start_req[0] = 1'b1;
   hold_off = 4'h0;
   n = 0;
   while (cts_active[0] !== 1'b1 && n < 50)
   begin
      cyc(1);
      n = n + 1;
   end
   n = 0;
   while (tx_start[0] !== 1'b1 && n < 400)
   begin
      cyc(1);
      n = n + 1;
   end
   chk_val(n >= UNIT * units && n <= UNIT * units + 8, 1'b1);
end
endtask
initial
begin
   mclk = 1'b0;
   forever #2 mclk = ~mclk;
end
// scoreboard: every ack retires the oldest note, reads are compared
always @(posedge mclk)
   if (rst_b && reg_ack === 1'b1)
   begin
      // an acknowledge with no access outstanding is itself a mismatch
      if (notes.size() == 0)
         chk_val({15'h0000, reg_ack}, 16'h0000);
      else
      begin
         note = notes.pop_front();
         if (note[16])
            chk_val(reg_rdata, note[15:0]);
      end
   end
initial
begin
   #(20000 * 4);
   n_mismatch = n_mismatch + 1;
   end_sim;
end
initial
begin
   {reg_wr, reg_rd, reg_addr, reg_wdata, port_mode, drive_mode} = 0;
   {tx_pending, tx_start_req, rx_congested, checksum_sent, byte_sent, ack_seen} = 0;
   hold_off = 4'hF;
   n_mismatch = 0;
   n_tests = 0;
   seed = 32'hd7f80f74;
   rst_b = 1'b0;
   cyc(2);
   rst_b = 1'b1;
   cyc(1);
   for (i = 0; i < 4; i = i + 1)
   begin
      chk_val(pad_count[16*i +: 16], `RST_PAD_COUNT);
      reg_acc(1'b1, addr(16'h0818, i), 16'h0000, `RST_STAT_WORD);
      reg_acc(1'b1, addr(16'h1F80, i), 16'h0000, `RST_CFG_WORD);
      rnd = $random(seed);
      rv = rnd[15:0];
      reg_acc(1'b0, addr(16'h1F6A, i), rv, 16'h0000);
      reg_acc(1'b1, addr(16'h1F6A, i), 16'h0000, rv);
      rnd = $random(seed);
      pad_v[i] = (i == 1) ? 16'h0009 : (i == 2) ? 16'h000A : rnd[15:0];
      reg_acc(1'b0, addr(16'h1F80, i), pad_v[i], 16'h0000);
      reg_acc(1'b1, addr(16'h1F80, i), 16'h0000, pad_v[i]);
      reg_acc(1'b0, addr(16'h0818, i), rv, 16'h0000);
      reg_acc(1'b1, addr(16'h0818, i), 16'h0000, `RST_STAT_WORD);
      chk_val(pad_count[16*i +: 16], pad_exp(pad_v[i]));
   end
   reg_acc(1'b1, 16'h1F81, 16'h0000, 16'h0000);
   port_mode = 16'h3210;
   cyc(2);
   for (i = 0; i < 4; i = i + 1)
      chk_val(pad_count[16*i +: 16], (i == 3) ? `PAD_COUNT_MIN : pad_exp(pad_v[i]));
   for (i = 0; i < 11; i = i + 1)
   begin
      port_mode[3:0] = i[3:0];
      cyc(3);
      chk_val(rts_active[0], i < 6);
   end
   port_mode[3:0] = 4'h0;
   rx_congested = 4'hF;
   cyc(3);
   chk_val(rts_active, 4'h0);
   rx_congested = 4'h0;
   cyc(2);
   chk_val(rts_active, 4'hF);
   rnd = $random(seed);
   checksum_sent = 4'hF;
   cyc(1);
   checksum_sent = 4'h0;
   repeat (rnd[2:0] + 1)
   begin
      byte_sent = 4'hF;
      cyc(1);
      byte_sent = 4'h0;
      cyc(1);
   end
   ack_seen = 4'hF;
   cyc(1);
   ack_seen = 4'h0;
   cyc(1);
   for (i = 0; i < 4; i = i + 1)
      reg_acc(1'b1, addr(16'h0818, i), 16'h0000, {13'h0000, rnd[2:0]} + 16'h0001);
   // pad from statistic
   // configuring side sets pad ten percent above the statistic plus a turnaround margin
   rv = ((({13'h0000, rnd[2:0]} + 16'h0001) * 16'h000B) / 16'h000A) + `PAD_COUNT_MIN;
   reg_acc(1'b0, addr(16'h1F80, 1), rv, 16'h0000);
   chk_val(pad_count[31:16], pad_exp(rv));
   drive_mode = 8'h01;
   reg_acc(1'b0, 16'h1F80, 16'h0002, 16'h0000);
   reg_acc(1'b0, 16'h1F6A, 16'h0001, 16'h0000);
   for (i = 6; i < 10; i = i + 1)
      delay_run(i[3:0], 2);
   delay_run(`MODE_REMOTE_NETWORK, 1);
   for (i = 0; i < 4; i = i + 1)
   begin
      drive_mode[1:0] = i[1:0];
      n = 0;
      cyc(8);
      while (tx_busy[0] !== 1'b1 && n < 100)
      begin
         cyc(1);
         n = n + 1;
      end
      chk_val(rcv_en[0], !i[1]);
      chk_val(drv_en[0], 1'b1);
   end
   drive_mode[1:0] = `DRIVE_FOUR_WIRE;
   hold_off[0] = 1'b1;
   cyc(8);
   n = 0;
   repeat (20)
   begin
      cyc(1);
      n = n + tx_start[0];
   end
   chk_val(n[15:0], 16'h0000);
   chk_val(drv_en[0], 1'b0);
   drive_mode[1:0] = `DRIVE_POINT_LINK;
   cyc(3);
   chk_val(drv_en[0], 1'b1);
   tx_pending = 4'h0;
   tx_start_req = 4'h0;
   cyc(10);
   chk_val(rts_active[0], 1'b0);
   n = notes.size();
   chk_val(n[15:0], 16'h0000);
   end_sim;
end
endmodule
